// ===== cap_sense_scan_control.sv
// Purpose: start-source selection, auto-scan sequencing and threshold compare
// Assumes: analog front end answers each conv_start with one conv_done pulse
// Notes: registers reached over a plain strobe port, read data one cycle later
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_defs.svh"

module cap_sense_scan_control (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire cap_sense_pkg::byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output cap_sense_pkg::byte_type reg_rdata,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic [15:0] analog_pin_mask,
  input wire logic suspend_active,
  output logic conv_start,
  output cap_sense_pkg::chan_type conv_channel,
  input wire logic conv_done,
  input wire cap_sense_pkg::word_type conv_result,
  output logic conv_done_irq,
  output logic greater_than_irq,
  output logic wake_req
);
  import cap_sense_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  seq_state_type state_reg;
  logic busy_reg;
  logic armed_reg;
  logic flag_reg;
  byte_type cfg_reg;
  chan_type mux_reg;
  chan_type ss_reg;
  chan_type se_reg;
  word_type thr_reg;
  word_type data_reg;
  logic [1:0] irq_en_reg;
  logic [4:0] cnt_reg;
  word_type acc_sum;

  logic wr_ctrl;
  logic busy_write;
  logic [2:0] src;
  logic is_scan;
  logic is_cont;
  logic trig;
  logic start_seq;
  logic [4:0] acc_target;
  logic conv_step;
  logic last_conv;
  logic in_compare;
  logic gt_now;
  logic restart;

  // lowest analog channel above cur, not past last; last itself if none
  function automatic chan_type next_chan(input chan_type cur, input chan_type last,
                                         input logic [15:0] mask);
    chan_type r;
    r = last;
    for (int i = 15; i >= 0; i--) begin
      if (i > int'(cur) && i < int'(last) && mask[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : next_chan

  // ----------------------------------------------------------------
  // decode and sequencing terms
  // ----------------------------------------------------------------
  assign wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
  assign busy_write = wr_ctrl && reg_wdata[`CTRL_BUSY_BIT];
  assign src = cfg_reg[`CFG_SRC_HI:`CFG_SRC_LO];
  assign is_scan = (src == `SRC_SCAN);
  assign is_cont = (src == `SRC_CONT) || is_scan;
  assign in_compare = (state_reg == st_compare);
  assign conv_step = conv_done && (state_reg == st_convert);
  assign last_conv = conv_step && ((cnt_reg + `CNT_ONE) == acc_target);
  assign gt_now = in_compare && (acc_sum > thr_reg);
  // a scan that hit the threshold only restarts on a fresh busy write
  assign restart = in_compare && is_cont && (busy_write || (armed_reg && !(is_scan && gt_now)));
  assign start_seq = (state_reg == st_idle) && trig;
  assign conv_channel = mux_reg;

  // trigger chosen by the start-source field
  always_comb begin
    case (src)
      `SRC_SW: trig = busy_write;
      `SRC_T0: trig = timer0_ovf;
      `SRC_T2: trig = timer2_ovf;
      `SRC_T1: trig = timer1_ovf;
      `SRC_CONT, `SRC_SCAN: trig = busy_write || armed_reg;
      default: trig = busy_write;
    endcase
  end

  // conversions per visit; a scanned non-analog channel gets a single try
  always_comb begin
    case (cfg_reg[`CFG_ACC_HI:`CFG_ACC_LO])
      `ACC_CODE_1: acc_target = `ACC_N1;
      `ACC_CODE_4: acc_target = `ACC_N4;
      `ACC_CODE_8: acc_target = `ACC_N8;
      default: acc_target = `ACC_N16;
    endcase
    if (is_scan && !analog_pin_mask[mux_reg]) begin
      acc_target = `ACC_N1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // no suspend input here: the scan runs on regardless of it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: if (start_seq) state_reg <= st_convert;
        st_convert: if (last_conv) state_reg <= st_compare;
        st_compare: state_reg <= restart ? st_convert : st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  // one pulse per conversion, also between accumulated ones
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_seq || restart || (conv_step && !last_conv);
    end
  end

  // conversions done in this visit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= `RST_CNT;
    end else if (start_seq || restart) begin
      cnt_reg <= `RST_CNT;
    end else if (conv_step) begin
      cnt_reg <= cnt_reg + `CNT_ONE;
    end
  end

  sample_accumulator #(.WIDTH(16)) u_accum (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(start_seq || restart),
    .add(conv_step),
    .sample(conv_result),
    .sum(acc_sum)
  );

  // busy stays up across back-to-back visits; the write's set wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
    end else if (busy_write || start_seq) begin
      busy_reg <= 1'b1;
    end else if (in_compare && !restart) begin
      busy_reg <= 1'b0;
    end
  end

  // continuous run permission
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= 1'b0;
    end else if (busy_write && is_cont) begin
      armed_reg <= 1'b1;
    end else if (reg_wr && (reg_addr == `ADDR_CFG)) begin
      armed_reg <= 1'b0;
    end else if (in_compare && is_scan && gt_now) begin
      armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // compare result and events
  // ----------------------------------------------------------------
  // hardware compare wins over a firmware write in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (in_compare) begin
      flag_reg <= gt_now;
    end else if (wr_ctrl) begin
      flag_reg <= reg_wdata[`CTRL_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_reg <= `RST_WORD;
    end else if (in_compare) begin
      data_reg <= acc_sum;
    end
  end

  // one-cycle event pulses; wake ignores the interrupt enables
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_done_irq <= 1'b0;
      greater_than_irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      conv_done_irq <= in_compare && irq_en_reg[`IRQ_EN_DONE_BIT];
      greater_than_irq <= gt_now && irq_en_reg[`IRQ_EN_GT_BIT];
      wake_req <= gt_now && suspend_active;
    end
  end

  // ----------------------------------------------------------------
  // channel select
  // ----------------------------------------------------------------
  // scan advance wins over a firmware write in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mux_reg <= `RST_CHAN;
    end else if (in_compare && is_scan && restart) begin
      if (mux_reg >= se_reg) begin
        mux_reg <= ss_reg;
      end else begin
        mux_reg <= next_chan(mux_reg, se_reg, analog_pin_mask);
      end
    end else if (reg_wr && (reg_addr == `ADDR_MUX)) begin
      mux_reg <= reg_wdata[3:0];
    end else if (reg_wr && (reg_addr == `ADDR_SCAN_START) && is_scan) begin
      mux_reg <= reg_wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // plain configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= `RST_BYTE;
      ss_reg <= `RST_CHAN;
      se_reg <= `RST_CHAN;
      thr_reg <= `RST_WORD;
      irq_en_reg <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CFG: cfg_reg <= reg_wdata;
        `ADDR_SCAN_START: ss_reg <= reg_wdata[3:0];
        `ADDR_SCAN_END: se_reg <= reg_wdata[3:0];
        `ADDR_THR_LOW: thr_reg[7:0] <= reg_wdata;
        `ADDR_THR_HIGH: thr_reg[15:8] <= reg_wdata;
        `ADDR_IRQ_EN: irq_en_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // read data stands for one cycle only; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL: reg_rdata <= {3'h0, busy_reg, 3'h0, flag_reg};
        `ADDR_CFG: reg_rdata <= cfg_reg;
        `ADDR_MUX: reg_rdata <= {4'h0, mux_reg};
        `ADDR_SCAN_START: reg_rdata <= {4'h0, ss_reg};
        `ADDR_SCAN_END: reg_rdata <= {4'h0, se_reg};
        `ADDR_THR_LOW: reg_rdata <= thr_reg[7:0];
        `ADDR_THR_HIGH: reg_rdata <= thr_reg[15:8];
        `ADDR_DATA_LOW: reg_rdata <= data_reg[7:0];
        `ADDR_DATA_HIGH: reg_rdata <= data_reg[15:8];
        `ADDR_IRQ_EN: reg_rdata <= {6'h00, irq_en_reg};
        default: reg_rdata <= `RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_sw_start: assert property (
    (state_reg == st_idle && src == `SRC_SW && busy_write) |=> conv_start ##1 busy_reg)
    else $error("software start did not begin a conversion");
  chk_timer_src: assert property (
    (state_reg == st_idle && src == `SRC_T2 && timer2_ovf) |=> conv_start)
    else $error("timer overflow did not start a conversion");
  chk_cont_wait: assert property (
    (state_reg == st_idle && is_cont && !armed_reg && !busy_write) |=> !conv_start)
    else $error("continuous mode started without busy write");
  chk_done_irq: assert property (
    $rose(conv_done_irq) |-> $past(in_compare) && $past(cnt_reg) == $past(acc_target))
    else $error("done interrupt before final conversion");
  chk_scan_copy: assert property (
    (reg_wr && reg_addr == `ADDR_SCAN_START && is_scan && !in_compare)
    |=> mux_reg == $past(reg_wdata[3:0]))
    else $error("scan start write not copied to channel select");
  chk_scan_wrap: assert property (
    (in_compare && is_scan && restart && mux_reg >= se_reg) |=> mux_reg == $past(ss_reg))
    else $error("scan did not reload start channel");
  chk_scan_step: assert property (
    (in_compare && is_scan && restart && mux_reg < se_reg) |=> mux_reg > $past(mux_reg))
    else $error("scan did not step to a higher channel");
  chk_flag_value: assert property (
    in_compare |=> flag_reg == ($past(acc_sum) > $past(thr_reg)))
    else $error("compare flag disagrees with threshold");
  chk_flag_timing: assert property (
    ($changed(flag_reg) && !$past(wr_ctrl)) |-> $past(in_compare))
    else $error("compare flag moved outside a compare");
  chk_gt_irq: assert property (
    (gt_now && irq_en_reg[`IRQ_EN_GT_BIT]) |=> greater_than_irq)
    else $error("greater-than interrupt missing");
  chk_gt_stop: assert property (
    (in_compare && is_scan && gt_now && !busy_write)
    |=> (state_reg == st_idle) ##1 (state_reg == st_idle || $past(busy_write)))
    else $error("scan continued after greater-than event");
  chk_wake_event: assert property (
    (gt_now && suspend_active) |=> wake_req)
    else $error("greater-than event did not wake");
  chk_busy_clear: assert property (
    (in_compare && !restart && !busy_write) |=> !busy_reg)
    else $error("busy stayed set after sequence end");

  cov_scan_wrap: cover property (in_compare && is_scan && restart && mux_reg >= se_reg);
  cov_wake: cover property (gt_now && suspend_active);
  cov_accum_four: cover property (in_compare && acc_target == `ACC_N4);
  cov_timer_start: cover property (start_seq && src == `SRC_T0);
endmodule : cap_sense_scan_control
`default_nettype wire

// ===== cap_sense_defs.svh
// Purpose: register offsets, field positions, codes and reset values of the scan control
// Assumes: 8-bit register data, 4-bit register address
// Notes: definitions only
`ifndef CAP_SENSE_DEFS_SVH
`define CAP_SENSE_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_CFG 4'h1
`define ADDR_MUX 4'h2
`define ADDR_SCAN_START 4'h3
`define ADDR_SCAN_END 4'h4
`define ADDR_THR_LOW 4'h5
`define ADDR_THR_HIGH 4'h6
`define ADDR_DATA_LOW 4'h7
`define ADDR_DATA_HIGH 4'h8
`define ADDR_IRQ_EN 4'h9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_BUSY_BIT 4
`define CTRL_FLAG_BIT 0
`define CFG_SRC_HI 6
`define CFG_SRC_LO 4
`define CFG_ACC_HI 1
`define CFG_ACC_LO 0
`define IRQ_EN_DONE_BIT 0
`define IRQ_EN_GT_BIT 1

// ----------------------------------------------------------------
// start-source codes and accumulate counts
// ----------------------------------------------------------------
`define SRC_SW 3'h0
`define SRC_T0 3'h1
`define SRC_T2 3'h2
`define SRC_T1 3'h3
`define SRC_CONT 3'h4
`define SRC_SCAN 3'h7
`define ACC_CODE_1 2'h0
`define ACC_CODE_4 2'h1
`define ACC_CODE_8 2'h2
`define ACC_N1 5'h01
`define ACC_N4 5'h04
`define ACC_N8 5'h08
`define ACC_N16 5'h10

// ----------------------------------------------------------------
// reset values and count step
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_CHAN 4'h0
`define RST_WORD 16'h0000
`define RST_CNT 5'h00
`define CNT_ONE 5'h01

`endif

// ===== cap_sense_pkg.sv
// Purpose: shared types of the capacitive-sense scan control
// Assumes: nothing beyond the defs header
// Notes: types only; numbers live in cap_sense_defs.svh
package cap_sense_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [3:0] chan_type;
  typedef logic [15:0] word_type;
  typedef enum logic [1:0] {st_idle, st_convert, st_compare} seq_state_type;
endpackage : cap_sense_pkg

// ===== sample_accumulator.sv
// Purpose: sums conversion results of one channel visit
// Assumes: clear and add never high together
// Notes: the sum wraps at its width; firmware picks counts that fit
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_defs.svh"

module sample_accumulator #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  input wire logic add,
  input wire logic [WIDTH-1:0] sample,
  output logic [WIDTH-1:0] sum
);
  // ----------------------------------------------------------------
  // running sum
  // ----------------------------------------------------------------
  // clear starts a fresh visit, add folds in one result
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sum <= '0;
    end else if (clear) begin
      sum <= '0;
    end else if (add) begin
      sum <= sum + sample;
    end
  end
endmodule : sample_accumulator
`default_nettype wire

// ===== cap_sense_front_end_model.sv
// Purpose: behavioural analog front end answering each conversion request
// Assumes: one conv_start at a time, slow sets the extra answer delay
// Notes: result is only held in the done cycle, inverted afterwards
`timescale 1ns/1ps
`default_nettype none
module cap_sense_front_end_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic conv_start,
  input wire logic [3:0] slow,
  input wire cap_sense_pkg::word_type sample_value,
  output logic conv_done,
  output cap_sense_pkg::word_type conv_result
);
  import cap_sense_pkg::*;
  int wait_cnt;
  word_type last_reg;
  // ----------------------------------------------------------------
  // one done pulse per start, never in the start cycle itself
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= 16'h0000;
      last_reg <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~last_reg; // stale data must not look valid
      if (conv_start) begin
        wait_cnt <= int'(slow) + 1;
      end else if (wait_cnt == 1) begin
        conv_done <= 1'b1;
        conv_result <= sample_value;
        last_reg <= sample_value;
        wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : cap_sense_front_end_model
`default_nettype wire

// ===== tb_cap_sense_scan_control.sv
// Purpose: self-checking bench of the scan control
// Assumes: front end model answers every start
// Notes: expectations come from integer models in this file
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_defs.svh"
module tb_cap_sense_scan_control;
  import cap_sense_pkg::*;
  logic clk_sys, resetn, reg_wr, reg_rd, suspend_active, conv_start, conv_done;
  logic conv_done_irq, greater_than_irq, wake_req;
  logic [2:0] tmr;
  logic [3:0] reg_addr, slow;
  logic [15:0] analog_pin_mask;
  byte_type reg_wdata, reg_rdata, rv;
  chan_type conv_channel;
  word_type conv_result, sample_value;
  int err_count, compares, n_start, n_done, n_gt, n_wake, cycles, s0, c;
  int chan_q[$], exp_q[$];

  cap_sense_scan_control cap_sense_scan_control_inst (.clk_sys, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer0_ovf(tmr[0]), .timer1_ovf(tmr[1]),
    .timer2_ovf(tmr[2]), .analog_pin_mask, .suspend_active, .conv_start, .conv_channel,
    .conv_done, .conv_result, .conv_done_irq, .greater_than_irq, .wake_req);
  cap_sense_front_end_model cap_sense_front_end_model_inst (.clk_sys, .resetn,
    .conv_start, .slow, .sample_value, .conv_done, .conv_result);

  // ----------------------------------------------------------------
  // clock, event monitor and hang limit
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (resetn && conv_start) begin
      n_start++;
      chan_q.push_back(int'(conv_channel));
    end
    if (resetn && conv_done_irq) n_done++;
    if (resetn && greater_than_irq) n_gt++;
    if (resetn && wake_req) n_wake++;
    // hang limit, checked last so nothing runs after the verdict
    if (cycles > 20000) begin
      err_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input byte_type d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic wait_irq(input int target);
    for (int i = 0; i < 600 && n_done < target; i++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask : wait_irq
  task automatic set_thr(input word_type t);
    wr(`ADDR_THR_LOW, t[7:0]);
    wr(`ADDR_THR_HIGH, t[15:8]);
  endtask : set_thr
  // one busy-started visit of n accumulated conversions
  task automatic sw_conv(input word_type s, input word_type t, input int n);
    int d0, g0;
    logic [15:0] sum;
    d0 = n_done;
    g0 = n_gt;
    s0 = n_start;
    sum = 16'(int'(s) * n);
    sample_value <= s;
    set_thr(t);
    wr(`ADDR_CTRL, 8'h10);
    rd(`ADDR_CTRL);
    check(16'(rv[4]), 16'h1); // busy while running
    wait_irq(d0 + 1);
    check(16'(n_start - s0), 16'(n)); // conversions per start
    check(16'(n_done - d0), 16'h1); // one done pulse per visit
    rd(`ADDR_CTRL);
    check(16'(rv), {15'h0, sum > t}); // flag and idle busy
    check(16'(n_gt - g0), {15'h0, sum > t}); // greater-than pulse
    rd(`ADDR_DATA_LOW);
    check(16'(rv), {8'h00, sum[7:0]}); // summed low byte
    rd(`ADDR_DATA_HIGH);
    check(16'(rv), {8'h00, sum[15:8]}); // summed high byte
  endtask : sw_conv
  // scan order model: next analog channel below end, else end, then start
  function automatic int next_ch(input int ch, input int s, input int e, input logic [15:0] m);
    if (ch >= e) return s;
    for (int k = ch + 1; k < e; k++) begin
      if (m[k]) return k;
    end
    return e;
  endfunction : next_ch
  task automatic complete_run();
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {reg_wr, reg_rd, suspend_active, tmr, slow} = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    analog_pin_mask = 16'hffff;
    sample_value = 16'h0000;
    void'($urandom(30));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 11; a++) begin
      rd(a[3:0]);
      check(16'(rv), 16'h0000); // all registers clear, unmapped reads zero
    end
    wr(`ADDR_IRQ_EN, 8'h03);
    // compare at the boundary and on random values, random answer delay
    for (int i = 0; i < 6; i++) begin
      word_type t;
      t = 16'($urandom) & 16'h7fff;
      slow <= 4'($urandom);
      sw_conv((i == 0) ? t : (i == 1) ? t + 16'h1 : 16'($urandom), t, 1);
    end
    // every accumulate code
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_CFG, {6'h00, 2'(k)});
      sw_conv(16'h0123, 16'h0400, 1 << (k == 0 ? 0 : k + 1));
    end
    // timer codes: wrong overflows ignored, the chosen one starts
    set_thr(16'hffff);
    for (int k = 1; k < 4; k++) begin
      c = (k == 1) ? 0 : (k == 2) ? 2 : 1;
      wr(`ADDR_CFG, {1'b0, 3'(k), 4'h0});
      s0 = n_start;
      tmr <= 3'h7 & ~(3'h1 << c);
      @(posedge clk_sys);
      tmr <= 3'h0;
      repeat (10) @(posedge clk_sys);
      check(16'(n_start - s0), 16'h0); // other timers ignored
      tmr <= 3'h1 << c;
      @(posedge clk_sys);
      tmr <= 3'h0;
      wait_irq(n_done + 1);
      check(16'(n_start - s0), 16'h1); // chosen timer starts
    end
    // continuous waits for busy, then repeats until disarmed
    wr(`ADDR_CFG, 8'h40);
    s0 = n_start;
    repeat (20) @(posedge clk_sys);
    check(16'(n_start - s0), 16'h0); // no start before busy
    wr(`ADDR_CTRL, 8'h10);
    repeat (100) @(posedge clk_sys); // room for five visits at the slowest answer
    check(16'(n_start - s0 >= 5), 16'h1); // back to back
    wr(`ADDR_CFG, 8'h00);
    // let the visit in flight end, else a busy write would re-arm it
    repeat (40) @(posedge clk_sys);
    // auto-scan over 2..6 with 3 and 5 analog, four per analog visit, in suspend
    analog_pin_mask <= 16'h0028; // only these pins are set analog
    suspend_active <= 1'b1; // scan keeps going
    wr(`ADDR_CFG, 8'h71);
    wr(`ADDR_SCAN_END, 8'h06);
    wr(`ADDR_SCAN_START, 8'h02);
    rd(`ADDR_MUX);
    check(16'(rv), 16'h0002); // start copied to channel select
    chan_q.delete();
    wr(`ADDR_CTRL, 8'h10);
    for (int i = 0; i < 900 && chan_q.size() < 24; i++) @(posedge clk_sys);
    // keep the count of four so the visit in flight ends cleanly, then let it drain
    wr(`ADDR_CFG, 8'h01);
    repeat (80) @(posedge clk_sys);
    c = 2;
    while (exp_q.size() < 24) begin
      repeat (analog_pin_mask[c] ? 4 : 1) exp_q.push_back(c);
      c = next_ch(c, 2, 6, analog_pin_mask);
    end
    for (int i = 0; i < 24; i++) begin
      check(16'(chan_q[i]), 16'(exp_q[i])); // step, wrap, single tries
    end
    // greater-than in scan stops it and wakes, interrupt disabled
    wr(`ADDR_IRQ_EN, 8'h01);
    set_thr(16'h0100);
    sample_value <= 16'h0200;
    wr(`ADDR_CFG, 8'h70);
    wr(`ADDR_SCAN_START, 8'h02);
    s0 = n_start;
    c = n_gt;
    wr(`ADDR_CTRL, 8'h10);
    wait_irq(n_done + 1);
    repeat (40) @(posedge clk_sys);
    check(16'(n_start - s0), 16'h1); // scan halted on flag
    check(16'(n_wake), 16'h1); // wake without interrupt
    check(16'(n_gt - c), 16'h0); // disabled greater-than stays quiet
    repeat (2) @(posedge clk_sys); // firmware pause after wake
    wr(`ADDR_CTRL, 8'h10);
    wait_irq(n_done + 1);
    check(16'(n_start - s0), 16'h2); // busy write resumes
    complete_run();
  end
endmodule : tb_cap_sense_scan_control
`default_nettype wire
